// [sim/exec_model.sv]
// Far-side model of the command executor: takes one entry at a time.
// Assumes the intake holds exec_valid until the edge after exec_done.
`timescale 1ns/1ps
`default_nettype none
module exec_model #(
  parameter int DLY = 3
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              stall,
  input  wire logic              exec_valid,
  input  wire cmdq_pkg::qentry_t exec_entry,
  output logic                   exec_done,
  output logic [31:0]            exec_ind_data
);
  // ==========================================================
  // Completion engine and log of executed entries
  logic [31:0] seen_cmd [64];
  logic [31:0] seen_par [64];
  int          n_seen;
  int          cnt;
  logic        sent;

  always @(posedge aclk) begin
    if (!aresetn) begin
      exec_done <= 1'b0;
      exec_ind_data <= 32'h0000_0000;
      n_seen <= 0;
      cnt <= 0;
      sent <= 1'b0;
    end else if (exec_valid && !sent && !stall && cnt == DLY) begin
      exec_done <= 1'b1;
      exec_ind_data <= {2'b00, exec_entry.cmd[29:0] ^ 30'h1555_5555};
      sent <= 1'b1;
      seen_cmd[n_seen] <= exec_entry.cmd;
      seen_par[n_seen] <= exec_entry.param;
      n_seen <= n_seen + 1;
    end else begin
      exec_done <= 1'b0;
      // Idle data toggles, so a stale indication is never mistaken for new.
      exec_ind_data <= ~exec_ind_data;
      if (!exec_valid) begin
        sent <= 1'b0;
        cnt <= 0;
      end else if (!sent && !stall) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/host_command_queue_lock_tb_top.sv]
// Self-checking bench for the command intake on the generic bus, then in queued mode.
// Assumes the executor model above and one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module host_command_queue_lock_tb_top;
  localparam int         LIM   = 400;
  localparam logic [11:0] A_CMD = {cmdq_pkg::IDX_CMD, 2'b00};
  localparam logic [11:0] A_CML = {cmdq_pkg::IDX_CMD_L, 2'b00};
  localparam logic [11:0] A_PAR = {cmdq_pkg::IDX_PAR, 2'b00};
  localparam logic [11:0] A_PAL = {cmdq_pkg::IDX_PAR_L, 2'b00};
  localparam logic [11:0] A_DEP = {cmdq_pkg::IDX_DEPTH, 2'b00};
  localparam logic [11:0] A_MOD = {cmdq_pkg::IDX_MODE, 2'b00};
  localparam logic [31:0] TX    = 32'h3000_0010;

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [11:0]       awaddr = 12'h000;
  logic              awvalid = 1'b0;
  logic [31:0]       wdata = 32'h0000_0000;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic [11:0]       araddr = 12'h000;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              stall = 1'b0;
  logic              pci_pin = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata, d, ind_data;
  logic [1:0]        r;
  logic              exec_valid, exec_done;
  cmdq_pkg::qentry_t exec_entry;
  int                n_mismatch = 0;
  int                checks = 0;
  int                k;

  always #2.5 aclk = ~aclk;

  cmd_intake uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .bus_is_pci(pci_pin),
    .exec_valid(exec_valid), .exec_entry(exec_entry),
    .exec_done(exec_done), .exec_ind_data(ind_data));

  exec_model far (.aclk(aclk), .aresetn(aresetn), .stall(stall),
    .exec_valid(exec_valid), .exec_entry(exec_entry),
    .exec_done(exec_done), .exec_ind_data(ind_data));

  // ==========================================================
  // Bus tasks and reporting
  task automatic final_report;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > LIM) begin
      n_mismatch++;
      final_report;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    bit ad;
    bit wd;
    n = 0;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      guard(n);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic poll_idle;
    int n;
    n = 0;
    do begin
      rd(A_CMD);
      guard(n);
    end while (d[cmdq_pkg::BIT_BUSY] !== 1'b0);
  endtask

  task automatic wait_seen(input int want);
    int n;
    n = 0;
    while (far.n_seen < want) begin
      @(posedge aclk);
      guard(n);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_mode;
    rd(A_DEP);
    `CHK(d[3:0], cmdq_pkg::CNT_ZERO)
    rd(A_MOD);
    `CHK(d, cmdq_pkg::MODE_RESET)
    wr(A_MOD, 32'h0000_0001);
    rd(A_MOD);
    `CHK(d[cmdq_pkg::BIT_QMODE], 1'b1)
    // Generic bus: the select bit is ignored and a command written while busy is dropped.
    stall <= 1'b1;
    wr(A_CMD, TX);
    rd(A_CML);
    `CHK(d[cmdq_pkg::BIT_BUSY], 1'b1)
    wr(A_CMD, TX + 1);
    stall <= 1'b0;
    poll_idle;
    rd(A_CML);
    `CHK(far.n_seen, 1)
    pci_pin <= 1'b1;
    rd(12'h040);
    `CHK(r, cmdq_pkg::RESP_DECERR)
    wr(12'h040, 32'h0000_0001);
    `CHK(r, cmdq_pkg::RESP_DECERR)
  endtask

  task automatic t_lock;
    rd(A_CMD);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b0)
    rd(A_CMD);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b1)
    rd(A_CML);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b1)
    rd(A_PAR);
    rd(A_CMD);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b1)
    rd(A_PAL);
    rd(A_CMD);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b0)
    rd(A_CML);
    wr(A_PAR, 32'h0000_0005);
    wr(A_PAL, 32'h0000_0006);
    rd(A_CML);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b0)
    rd(A_CML);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b1)
  endtask

  task automatic t_busy;
    logic [31:0] op;
    op = {2'b00, cmdq_pkg::CODE_OPEN, 26'h0000_120};
    k = far.n_seen;
    stall <= 1'b1;
    rd(A_CMD);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b0)
    wr(A_PAR, 32'hcafe_0001);
    wr(A_CMD, op);
    rd(A_CML);
    `CHK(d[cmdq_pkg::BIT_BUSY], 1'b1)
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b1)
    rd(A_CML);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b1)
    // A second, plain command written while the open is outstanding is still accepted and queued.
    wr(A_CMD, TX);
    `CHK(r, cmdq_pkg::RESP_OKAY)
    stall <= 1'b0;
    poll_idle;
    `CHK(d[29:0], op[29:0] ^ 30'h1555_5555)
    rd(A_CML);
    wait_seen(k + 2);
    `CHK(far.seen_cmd[k], op)
    `CHK(far.seen_par[k], 32'hcafe_0001)
    `CHK(far.seen_cmd[k + 1], TX)
  endtask

  task automatic t_indirect;
    logic [31:0] ir;
    ir = {2'b00, cmdq_pkg::CODE_INDIR, 1'b1, 25'h0000_012};
    wr(A_CMD, ir);
    poll_idle;
    rd(A_PAR);
    `CHK(d, {2'b00, ir[29:0] ^ 30'h1555_5555})
    rd(A_PAL);
    rd(A_CMD);
    `CHK(d[cmdq_pkg::BIT_LOCK], 1'b0)
    rd(A_CML);
  endtask

  task automatic t_full;
    k = far.n_seen;
    stall <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      wr(A_CMD, TX + i);
      `CHK(r, cmdq_pkg::RESP_OKAY)
    end
    rd(A_DEP);
    `CHK(d[3:0], cmdq_pkg::QDEPTH)
    fork
      wr(A_CMD, TX + 11);
      begin
        repeat (20) begin
          @(posedge aclk);
          `CHK(bvalid, 1'b0)
        end
        stall <= 1'b0;
      end
    join
    `CHK(r, cmdq_pkg::RESP_OKAY)
    wait_seen(k + 12);
    for (int i = 0; i < 12; i++)
      `CHK(far.seen_cmd[k + i], TX + i)
    rd(A_DEP);
    `CHK(d[3:0], cmdq_pkg::CNT_ZERO)
    rd(A_CML);
    `CHK(d[cmdq_pkg::BIT_BUSY], 1'b0)
    wr(A_CMD, {2'b00, cmdq_pkg::CODE_CLOSE, 26'h0000_340});
    rd(A_CML);
    `CHK(d[cmdq_pkg::BIT_BUSY], 1'b1)
    poll_idle;
    rd(A_CML);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset_mode;
    t_lock;
    t_busy;
    t_indirect;
    t_full;
    final_report;
  end
endmodule
`default_nettype wire

// [verilog/cmd_intake.sv]
// Host command intake: AXI4-Lite registers, command queue, busy and lock.
// Assumes an executor that takes one entry at a time and pulses done.
//
// Overview of operation
// - Owner may issue more commands while locked.
// - Queued mode needs select bit and PCI bus.
// - Queue holds ten command entries with parameters.
// - In queued mode, command and parameter addresses stall while queue is full.
// - Depth register returns commands held in queue.
// - Busy set by indication commands until stored.
// - In queued mode, commands without indication never set busy.
// - In queued mode, no-indication commands accepted and queued unless queue full.
// - Lock flag sits at bit thirty.
// - Command and parameter reads lock; alias reads unlock when locked.
// - Queued mode writes leave lock unchanged.
// - Busy freezes the lock flag.
// - Commands execute strictly in arrival order.
// - Busy rises in the cycle after queueing.
// - Command and parameter each have alias address.
// - Busy flag sits at bit thirty-one.
// - Indication stored on the same edge that clears busy.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cmd_intake (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        bus_is_pci,
  output logic             exec_valid,
  output cmdq_pkg::qentry_t exec_entry,
  input  wire logic        exec_done,
  input  wire logic [31:0] exec_ind_data
);

  logic                awready_r, awready_nxt, wready_r, wready_nxt;
  logic                aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [9:0]          aw_idx_r, aw_idx_nxt, ar_idx_r, ar_idx_nxt;
  logic [31:0]         w_data_r, w_data_nxt;
  logic [3:0]          w_strb_r, w_strb_nxt;
  logic                bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]          bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic                arready_r, arready_nxt, ar_have_r, ar_have_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic [31:0]         word_r, word_nxt, par_r, par_nxt;
  logic [31:0]         mode_r, mode_nxt;
  logic                lock_r, lock_nxt;
  logic [3:0]          pend_r, pend_nxt;
  logic                pci_s1_r, pci_s2_r;
  cmdq_pkg::exec_st_t  st_r, st_nxt;
  cmdq_pkg::qentry_t   ex_r, ex_nxt, push_data, head;
  logic                exv_r, exv_nxt;
  logic                push, pop, full, empty, queued, busy;
  logic                wr_go, rd_go, wr_cmdish, rd_cmdish, push_ind;
  logic [3:0]          count;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_cmdish(input logic [9:0] idx);
    return idx == cmdq_pkg::IDX_CMD || idx == cmdq_pkg::IDX_CMD_L ||
           idx == cmdq_pkg::IDX_PAR || idx == cmdq_pkg::IDX_PAR_L;
  endfunction

  // ==========================================================
  // Queue and mode
  cmd_queue u_queue (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .head      (head),
    .count     (count),
    .full      (full),
    .empty     (empty)
  );

  // The bus strap is a pin, so it is synchronised before use.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_s1_r <= 1'b0;
      pci_s2_r <= 1'b0;
    end else begin
      pci_s1_r <= bus_is_pci;
      pci_s2_r <= pci_s1_r;
    end
  end

  assign queued    = mode_r[cmdq_pkg::BIT_QMODE] & pci_s2_r;
  assign busy      = (pend_r != cmdq_pkg::CNT_ZERO);
  assign wr_cmdish = is_cmdish(aw_idx_r);
  assign rd_cmdish = is_cmdish(ar_idx_r);
  assign wr_go     = aw_have_r && w_have_r && !bvalid_r &&
                     !(queued && full && wr_cmdish);
  assign rd_go     = ar_have_r && !rvalid_r &&
                     !(queued && full && rd_cmdish);
  assign push_ind  = push && push_data.ind;

  // ==========================================================
  // Register file, lock and pending count
  always_comb begin
    logic [31:0] w;
    logic [3:0]  code;
    logic        pend_up, pend_dn;
    w           = merge(word_r, w_data_r, w_strb_r);
    code        = w[cmdq_pkg::CODE_HI:cmdq_pkg::CODE_LO];
    aw_have_nxt = aw_have_r;
    aw_idx_nxt  = aw_idx_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    ar_have_nxt = ar_have_r;
    ar_idx_nxt  = ar_idx_r;
    bvalid_nxt  = bvalid_r && !bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r && !rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    word_nxt    = word_r;
    par_nxt     = par_r;
    mode_nxt    = mode_r;
    lock_nxt    = lock_r;
    push        = 1'b0;
    push_data   = '{cmd: w, param: par_r,
                    ind: 1'b0, rd_param: 1'b0};
    pend_up     = 1'b0;
    pend_dn     = 1'b0;
    if (awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      aw_idx_nxt  = awaddr[11:2];
    end
    if (wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (wr_go) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = cmdq_pkg::RESP_OKAY;
      unique case (aw_idx_r)
        cmdq_pkg::IDX_CMD, cmdq_pkg::IDX_CMD_L: begin
          push_data.rd_param = (code == cmdq_pkg::CODE_INDIR) &&
                               w[cmdq_pkg::BIT_IND_RD];
          if (queued) begin
            // Every command is queued; only some raise busy.
            push              = 1'b1;
            push_data.ind     = (code == cmdq_pkg::CODE_OPEN) ||
                                (code == cmdq_pkg::CODE_CLOSE) ||
                                push_data.rd_param;
            word_nxt[29:0]    = w[29:0];
          end else if (!busy) begin
            // Without the queue each command occupies the executor.
            push              = 1'b1;
            push_data.ind     = 1'b1;
            word_nxt[29:0]    = w[29:0];
            if (aw_idx_r == cmdq_pkg::IDX_CMD_L) begin
              lock_nxt = 1'b1;
            end
          end
        end
        cmdq_pkg::IDX_PAR, cmdq_pkg::IDX_PAR_L: begin
          par_nxt = merge(par_r, w_data_r, w_strb_r);
        end
        cmdq_pkg::IDX_MODE: begin
          mode_nxt = merge(mode_r, w_data_r, w_strb_r);
        end
        cmdq_pkg::IDX_DEPTH: begin
        end
        default: begin
          bresp_nxt = cmdq_pkg::RESP_DECERR;
        end
      endcase
    end
    if (arvalid && arready_r) begin
      ar_have_nxt = 1'b1;
      ar_idx_nxt  = araddr[11:2];
    end
    if (rd_go) begin
      ar_have_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = cmdq_pkg::RESP_OKAY;
      rdata_nxt   = 32'h0000_0000;
      unique case (ar_idx_r)
        cmdq_pkg::IDX_CMD, cmdq_pkg::IDX_CMD_L: begin
          rdata_nxt[29:0]               = word_r[29:0];
          rdata_nxt[cmdq_pkg::BIT_BUSY] = busy;
          rdata_nxt[cmdq_pkg::BIT_LOCK] = lock_r;
        end
        cmdq_pkg::IDX_PAR, cmdq_pkg::IDX_PAR_L: begin
          rdata_nxt = par_r;
        end
        cmdq_pkg::IDX_DEPTH: begin
          rdata_nxt[3:0] = count;
        end
        cmdq_pkg::IDX_MODE: begin
          rdata_nxt = mode_r;
        end
        default: begin
          rresp_nxt = cmdq_pkg::RESP_DECERR;
        end
      endcase
      // A read claims the device; an alias read hands it back.
      if (rd_cmdish && !busy) begin
        if (!lock_r) begin
          lock_nxt = 1'b1;
        end else if (ar_idx_r == cmdq_pkg::IDX_CMD_L ||
                     ar_idx_r == cmdq_pkg::IDX_PAR_L) begin
          lock_nxt = 1'b0;
        end
      end
    end
    // A completion lands its indication on the same edge that busy can drop.
    if (st_r == cmdq_pkg::EX_RUN && exec_done && ex_r.ind) begin
      pend_dn = 1'b1;
      if (ex_r.rd_param) begin
        par_nxt = exec_ind_data;
      end else begin
        word_nxt[29:0] = exec_ind_data[29:0];
      end
    end
    pend_up  = push && push_data.ind;
    pend_nxt = pend_r;
    if (pend_up && !pend_dn) begin
      pend_nxt = pend_r + cmdq_pkg::CNT_ONE;
    end else if (pend_dn && !pend_up) begin
      pend_nxt = pend_r - cmdq_pkg::CNT_ONE;
    end
    awready_nxt = !aw_have_nxt;
    wready_nxt  = !w_have_nxt;
    arready_nxt = !ar_have_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      arready_r <= 1'b0;
      aw_have_r <= 1'b0;
      aw_idx_r  <= 10'h000;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      ar_have_r <= 1'b0;
      ar_idx_r  <= 10'h000;
      bvalid_r  <= 1'b0;
      bresp_r   <= cmdq_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= cmdq_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
      word_r    <= cmdq_pkg::WORD_RESET;
      par_r     <= cmdq_pkg::WORD_RESET;
      mode_r    <= cmdq_pkg::MODE_RESET;
      lock_r    <= 1'b0;
      pend_r    <= cmdq_pkg::CNT_ZERO;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      arready_r <= arready_nxt;
      aw_have_r <= aw_have_nxt;
      aw_idx_r  <= aw_idx_nxt;
      w_have_r  <= w_have_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      ar_have_r <= ar_have_nxt;
      ar_idx_r  <= ar_idx_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      word_r    <= word_nxt;
      par_r     <= par_nxt;
      mode_r    <= mode_nxt;
      lock_r    <= lock_nxt;
      pend_r    <= pend_nxt;
    end
  end

  // ==========================================================
  // Executor hand-off, one entry at a time in queue order
  always_comb begin
    st_nxt  = st_r;
    ex_nxt  = ex_r;
    exv_nxt = exv_r;
    pop     = 1'b0;
    unique case (st_r)
      cmdq_pkg::EX_IDLE: begin
        if (!empty) begin
          pop     = 1'b1;
          ex_nxt  = head;
          exv_nxt = 1'b1;
          st_nxt  = cmdq_pkg::EX_RUN;
        end
      end
      cmdq_pkg::EX_RUN: begin
        if (exec_done) begin
          exv_nxt = 1'b0;
          st_nxt  = cmdq_pkg::EX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r  <= cmdq_pkg::EX_IDLE;
      ex_r  <= '0;
      exv_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      ex_r  <= ex_nxt;
      exv_r <= exv_nxt;
    end
  end

  assign awready    = awready_r;
  assign wready     = wready_r;
  assign bvalid     = bvalid_r;
  assign bresp      = bresp_r;
  assign arready    = arready_r;
  assign rvalid     = rvalid_r;
  assign rresp      = rresp_r;
  assign rdata      = rdata_r;
  assign exec_valid = exv_r;
  assign exec_entry = ex_r;

  // ==========================================================
  // Checks
  a_busy_on_push:
  assert property (@(posedge aclk) disable iff (!aresetn)
    push_ind |=> busy)
    else $error("busy not raised on queueing");
  a_noind_quiet:
  assert property (@(posedge aclk) disable iff (!aresetn)
    queued && push && !push_ind && pend_r == 4'h0 |=> pend_r == 4'h0)
    else $error("busy raised by plain command");
  a_full_stall:
  assert property (@(posedge aclk) disable iff (!aresetn)
    queued && full && aw_have_r && w_have_r && wr_cmdish && !bvalid_r
    |=> !bvalid_r)
    else $error("write answered while queue full");
  a_lock_take:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && rd_cmdish && !busy && !lock_r |=> lock_r)
    else $error("read did not lock");
  a_lock_alias:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && !busy && lock_r && (ar_idx_r == cmdq_pkg::IDX_CMD_L ||
    ar_idx_r == cmdq_pkg::IDX_PAR_L) |=> !lock_r)
    else $error("alias read did not unlock");
  a_lock_frozen:
  assert property (@(posedge aclk) disable iff (!aresetn)
    busy && !(wr_go && !queued) |=> $stable(lock_r))
    else $error("lock moved while busy");
  a_write_keeps:
  assert property (@(posedge aclk) disable iff (!aresetn)
    queued && wr_go && !rd_go |=> $stable(lock_r))
    else $error("queued write moved lock");
  a_depth_cap:
  assert property (@(posedge aclk) disable iff (!aresetn)
    count <= 4'ha)
    else $error("queue depth above ten");
  a_exec_hold:
  assert property (@(posedge aclk) disable iff (!aresetn)
    exv_r && !exec_done |=> exv_r && $stable(ex_r))
    else $error("executor entry changed early");
  a_ind_stored:
  assert property (@(posedge aclk) disable iff (!aresetn)
    exv_r && exec_done && ex_r.ind && !ex_r.rd_param
    |=> word_r[29:0] == $past(exec_ind_data[29:0]))
    else $error("indication not stored");

endmodule
`default_nettype wire

// [verilog/cmd_queue.sv]
// First-in first-out store of command entries held in flip-flops.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
`default_nettype none
module cmd_queue (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             push,
  input  wire cmdq_pkg::qentry_t push_data,
  input  wire logic             pop,
  output cmdq_pkg::qentry_t     head,
  output logic [3:0]            count,
  output logic                  full,
  output logic                  empty
);

  cmdq_pkg::qentry_t mem_r   [cmdq_pkg::QDEPTH];
  cmdq_pkg::qentry_t mem_nxt [cmdq_pkg::QDEPTH];
  logic [3:0]        wr_r, wr_nxt, rd_r, rd_nxt, cnt_r, cnt_nxt;

  // ==========================================================
  // Pointers and storage
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = push_data;
      wr_nxt = (wr_r == cmdq_pkg::QDEPTH - 4'h1) ? 4'h0 : wr_r + 4'h1;
    end
    // Entries leave strictly in arrival order.
    if (pop) begin
      rd_nxt = (rd_r == cmdq_pkg::QDEPTH - 4'h1) ? 4'h0 : rd_r + 4'h1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 4'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_r  <= 4'h0;
      rd_r  <= 4'h0;
      cnt_r <= 4'h0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Data words need no reset; only the pointers say what is valid.
  always_ff @(posedge aclk) begin
    mem_r <= mem_nxt;
  end

  assign head  = mem_r[rd_r];
  assign count = cnt_r;
  assign full  = (cnt_r == cmdq_pkg::QDEPTH);
  assign empty = (cnt_r == 4'h0);

endmodule
`default_nettype wire

// [verilog/cmdq_pkg.sv]
// Constants, field layouts and carrier types for the host command intake.
// Assumes one 200 MHz clock domain and a synchronous active-low reset.
package cmdq_pkg;

  // ==========================================================
  // Register map (index; byte address is four times it)
  localparam logic [9:0]  IDX_CMD     = 10'h008;
  localparam logic [9:0]  IDX_CMD_L   = 10'h009;
  localparam logic [9:0]  IDX_PAR     = 10'h00a;
  localparam logic [9:0]  IDX_PAR_L   = 10'h00b;
  localparam logic [9:0]  IDX_DEPTH   = 10'h00c;
  localparam logic [9:0]  IDX_MODE    = 10'h00d;
  localparam int          ADDR_W      = 12;

  // ==========================================================
  // Field positions and reset values
  localparam int          BIT_BUSY    = 31;
  localparam int          BIT_LOCK    = 30;
  localparam int          BIT_QMODE   = 0;
  localparam int          CODE_HI     = 29;
  localparam int          CODE_LO     = 26;
  localparam int          BIT_IND_RD  = 25;
  localparam logic [31:0] MODE_RESET  = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;

  // ==========================================================
  // Command codes that return an indication
  localparam logic [3:0]  CODE_OPEN   = 4'h8;
  localparam logic [3:0]  CODE_CLOSE  = 4'h9;
  localparam logic [3:0]  CODE_INDIR  = 4'he;

  // ==========================================================
  // Queue sizing and bus answers
  localparam logic [3:0]  QDEPTH      = 4'ha;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [31:0] cmd;
    logic [31:0] param;
    logic        ind;
    logic        rd_param;
  } qentry_t;

  typedef enum logic {EX_IDLE, EX_RUN} exec_st_t;

endpackage
